// ===== shared/iod_map.svh
/*
 Offsets, bit masks and fixed address limits of the I/O register space decoder.
 Assumes inclusion by the package and the decoder; definitions only.
*/
`ifndef IOD_MAP_SVH
`define IOD_MAP_SVH

// Offset from an I/O address to its data-space alias.
`define IOD_DATA_OFS      16'h0020
// Highest data address of the aliased I/O window.
`define IOD_DATA_TOP      16'h005F
// Extended I/O window, reached only by data-space loads and stores.
`define IOD_EXT_LOW       16'h0060
`define IOD_EXT_TOP       16'h00FF
// Highest I/O address for port instructions and for bit instructions.
`define IOD_PORT_TOP      16'h003F
`define IOD_BIT_TOP       16'h001F
// Value of every register after reset.
`define IOD_RESET_VAL     8'h00

// Register offsets (I/O numbering).
`define IOD_EEPROM_DATA      6'h20
`define IOD_EEPROM_ADDR_LOW  6'h21
`define IOD_EEPROM_ADDR_HIGH 6'h22
`define IOD_TIMER_SYNC_CTRL  6'h23
`define IOD_TIMER0_CTRL_A    6'h24
`define IOD_TIMER0_CTRL_B    6'h25
`define IOD_TIMER0_COUNT     6'h26
`define IOD_TIMER0_CMP_A     6'h27
`define IOD_TIMER0_CMP_B     6'h28
`define IOD_SCRATCH_1        6'h2A
`define IOD_SCRATCH_2        6'h2B
`define IOD_SPI_CTRL         6'h2C
`define IOD_SPI_STAT         6'h2D
`define IOD_SPI_BUFFER       6'h2E
`define IOD_CMP_CTRL_STAT    6'h30
`define IOD_SLEEP_CTRL       6'h33
`define IOD_RESET_CAUSE      6'h34
`define IOD_CPU_MISC_CTRL    6'h35
`define IOD_SELFPROG_CTRL    6'h37
`define IOD_STACK_PTR_LOW    6'h3D
`define IOD_STACK_PTR_HIGH   6'h3E
`define IOD_CORE_FLAGS       6'h3F
// Low-range flag registers.
`define IOD_FLAG_T0          6'h15
`define IOD_FLAG_T1          6'h16
`define IOD_FLAG_T2          6'h17
`define IOD_FLAG_PCHG        6'h1B
`define IOD_FLAG_EXT         6'h1C

// Masks packed as {readable, writable, clear-by-one}.
`define IOD_M_FULL       24'hFF_FF00
`define IOD_M_NONE       24'h00_0000
`define IOD_M_SYNC       24'h83_8300
`define IOD_M_T0A        24'hF3_F300
`define IOD_M_T0B        24'h0F_CF00
`define IOD_M_SPI_STAT   24'hC1_0100
`define IOD_M_CMP        24'hFF_CF10
`define IOD_M_LOW4       24'h0F_0F00
`define IOD_M_MISC       24'h13_1300
`define IOD_M_SELFPROG   24'hDF_9F00
`define IOD_M_SP_HIGH    24'h07_0700
`define IOD_M_FLAG3      24'h07_0007
`define IOD_M_FLAG_T1    24'h27_0027
`define IOD_M_FLAG2      24'h03_0003

`endif

// ===== shared/iod_pkg.sv
/*
 Types of the I/O register space decoder: operations, request, answer,
 hardware flag event and register mask.
 Assumes iod_map.svh is on the include path.
*/
package iod_pkg;
   `include "iod_map.svh"

   // Access classes that the core can issue.
   typedef enum logic [2:0] {
      OP_PORT_RD, OP_PORT_WR, OP_MEM_RD, OP_MEM_WR,
      OP_BIT_SET, OP_BIT_CLR, OP_SKIP_SET, OP_SKIP_CLR
   } iod_op_e;

   typedef struct packed {
      logic        valid;
      iod_op_e     op;
      logic [15:0] addr;
      logic [2:0]  bitSel;
      logic [7:0]  wdata;
   } iod_req_s;

   typedef struct packed {
      logic       valid;
      logic       refused;
      logic       passOn;
      logic       skip;
      logic [7:0] rdata;
   } iod_rsp_s;

   typedef struct packed {
      logic       valid;
      logic [5:0] ioAddr;
      logic [7:0] bits;
   } iod_evt_s;

   typedef struct packed {
      logic [7:0] rd;
      logic [7:0] wr;
      logic [7:0] c;
   } iod_mask_s;
endpackage : iod_pkg

// ===== logic/iod_decoder.sv
/*
 I/O register space decoder: 64 I/O registers reached by port, data-space
 and single-bit accesses, with hardware-set flags.
 Assumes the core presents at most one request per cycle and that peripherals
 raise flags through the event port.
*/
`timescale 1ns/1ps
`include "iod_map.svh"

// Operation
// - I/O registers alias into data space at I/O address plus 0x20.
// - Port instructions reach only I/O addresses 0x00 to 0x3F.
// - Data addresses 0x60 to 0xFF go onward via loads and stores only.
// - Bit set, clear and skip tests work on I/O 0x00 to 0x1F only.
// - A bit operation changes only the addressed bit.
// - Flags clear on a written one; a written zero leaves them.
module iod_decoder
   import iod_pkg::*;
(
   input  wire logic     sys_clk,
   input  wire logic     rst,
   input  wire iod_req_s req,
   input  wire iod_evt_s evt,
   output iod_rsp_s      rsp
);

   // Mask set of one I/O address; unlisted addresses up to 0x1F are plain full registers, unlisted ones above are reserved.
   function automatic iod_mask_s maskOf(input logic [5:0] a);
      logic [23:0] m;
      m = `IOD_M_NONE;
      case (a)
         `IOD_EEPROM_DATA, `IOD_EEPROM_ADDR_LOW, `IOD_EEPROM_ADDR_HIGH,
         `IOD_TIMER0_COUNT, `IOD_TIMER0_CMP_A, `IOD_TIMER0_CMP_B,
         `IOD_SCRATCH_1, `IOD_SCRATCH_2, `IOD_SPI_CTRL, `IOD_SPI_BUFFER,
         `IOD_STACK_PTR_LOW, `IOD_CORE_FLAGS: m = `IOD_M_FULL;
         `IOD_TIMER_SYNC_CTRL: m = `IOD_M_SYNC;
         `IOD_TIMER0_CTRL_A:   m = `IOD_M_T0A;
         `IOD_TIMER0_CTRL_B:   m = `IOD_M_T0B;
         `IOD_SPI_STAT:        m = `IOD_M_SPI_STAT;
         `IOD_CMP_CTRL_STAT:   m = `IOD_M_CMP;
         `IOD_SLEEP_CTRL, `IOD_RESET_CAUSE: m = `IOD_M_LOW4;
         `IOD_CPU_MISC_CTRL:   m = `IOD_M_MISC;
         `IOD_SELFPROG_CTRL:   m = `IOD_M_SELFPROG;
         `IOD_STACK_PTR_HIGH:  m = `IOD_M_SP_HIGH;
         `IOD_FLAG_T0, `IOD_FLAG_T2, `IOD_FLAG_PCHG: m = `IOD_M_FLAG3;
         `IOD_FLAG_T1:         m = `IOD_M_FLAG_T1;
         `IOD_FLAG_EXT:        m = `IOD_M_FLAG2;
         6'h00, 6'h01, 6'h02, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11,
         6'h12, 6'h13, 6'h14, 6'h18, 6'h19, 6'h1A: m = `IOD_M_NONE;
         default: m = (a <= 6'(`IOD_BIT_TOP)) ? `IOD_M_FULL : `IOD_M_NONE;
      endcase
      return iod_mask_s'(m);
   endfunction : maskOf

   // Bits that peripheral hardware may raise: readable but not writable.
   function automatic logic [7:0] hwMask(input logic [5:0] a);
      iod_mask_s m;
      m = maskOf(a);
      return m.rd & ~m.wr;
   endfunction : hwMask

   // Data-space address to I/O address.
   function automatic logic [5:0] ioFromData(input logic [15:0] a);
      logic [15:0] d;
      d = a - `IOD_DATA_OFS;
      return d[5:0];
   endfunction : ioFromData

   // Readable bits of one I/O address.
   function automatic logic [7:0] rdMask(input logic [5:0] a);
      iod_mask_s mm;
      mm = maskOf(a);
      return mm.rd;
   endfunction : rdMask

   // Writable bits of one I/O address.
   function automatic logic [7:0] wrMask(input logic [5:0] a);
      iod_mask_s mm;
      mm = maskOf(a);
      return mm.wr;
   endfunction : wrMask

   // Clear-by-one bits of one I/O address.
   function automatic logic [7:0] clrMask(input logic [5:0] a);
      iod_mask_s mm;
      mm = maskOf(a);
      return mm.c;
   endfunction : clrMask

   logic [7:0] ioMem [0:63];
   logic [7:0] next_mem [0:63];
   logic       hitIo;
   logic       bitOp;
   logic       isWr;
   logic       refuse;
   logic       passOn;
   logic [5:0] ioIdx;
   logic [7:0] cur;
   logic [7:0] act;
   logic [7:0] wd;
   logic [7:0] newVal;
   logic [7:0] rdVal;
   iod_mask_s  m;

   // Classifies the request and finds the I/O index it reaches.
   always_comb begin
      hitIo = 1'b0;
      bitOp = 1'b0;
      refuse = 1'b0;
      passOn = 1'b0;
      ioIdx = 6'h00;
      case (req.op)
         OP_PORT_RD, OP_PORT_WR: begin
            if (req.addr <= `IOD_PORT_TOP) begin
               hitIo = 1'b1;
               ioIdx = req.addr[5:0];
            end else begin
               refuse = 1'b1;
            end
         end
         OP_MEM_RD, OP_MEM_WR: begin
            if (req.addr >= `IOD_DATA_OFS && req.addr <= `IOD_DATA_TOP) begin
               hitIo = 1'b1;
               ioIdx = ioFromData(req.addr);
            end else begin
               passOn = 1'b1;
            end
         end
         OP_BIT_SET, OP_BIT_CLR, OP_SKIP_SET, OP_SKIP_CLR: begin
            if (req.addr <= `IOD_BIT_TOP) begin
               hitIo = 1'b1;
               bitOp = 1'b1;
               ioIdx = req.addr[5:0];
            end else begin
               refuse = 1'b1;
            end
         end
         default: refuse = 1'b1;
      endcase
      isWr = req.op == OP_PORT_WR || req.op == OP_MEM_WR ||
             req.op == OP_BIT_SET || req.op == OP_BIT_CLR;
   end

   // Forms the new register value; untouched and reserved bits keep theirs.
   always_comb begin
      cur = ioMem[ioIdx];
      m = maskOf(ioIdx);
      act = bitOp ? (8'h01 << req.bitSel) : 8'hFF;
      wd = bitOp ? ((req.op == OP_BIT_SET) ? act : 8'h00) : req.wdata;
      newVal = (cur & ~((m.wr | m.c) & act)) | (wd & m.wr & act)
             | (cur & m.c & act & ~wd);
      rdVal = cur & m.rd;
   end

   // Applies the write, then hardware flag events, so a set beats a clear.
   always_comb begin
      for (int k = 0; k < 64; k++) begin
         next_mem[k] = ioMem[k];
         if (req.valid && hitIo && isWr && ioIdx == 6'(k)) begin
            next_mem[k] = newVal;
         end
         if (evt.valid && evt.ioAddr == 6'(k)) begin
            next_mem[k] = next_mem[k] | (evt.bits & hwMask(6'(k)));
         end
      end
   end

   // Register storage.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int k = 0; k < 64; k++) begin
            ioMem[k] <= `IOD_RESET_VAL;
         end
      end else begin
         for (int k = 0; k < 64; k++) begin
            ioMem[k] <= next_mem[k];
         end
      end
   end

   // Answer one cycle after each request.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rsp <= '0;
      end else begin
         rsp.valid <= req.valid;
         rsp.refused <= req.valid && refuse;
         rsp.passOn <= req.valid && passOn;
         rsp.skip <= req.valid && hitIo && ((req.op == OP_SKIP_SET && rdVal[req.bitSel])
                     || (req.op == OP_SKIP_CLR && !rdVal[req.bitSel]));
         rsp.rdata <= (req.valid && hitIo && !isWr) ? rdVal : 8'h00;
      end
   end

   // Checks kept beside the logic.
   port_range_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      req.valid && (req.op == OP_PORT_RD || req.op == OP_PORT_WR) &&
      req.addr > `IOD_PORT_TOP |=> rsp.refused && !rsp.passOn)
      else $error("port access above I/O range not refused");

   bit_range_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      req.valid && req.op inside {OP_BIT_SET, OP_BIT_CLR, OP_SKIP_SET, OP_SKIP_CLR} &&
      req.addr > `IOD_BIT_TOP |=> rsp.refused && !rsp.skip)
      else $error("bit operation above bit range not refused");

   ext_pass_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      req.valid && (req.op == OP_MEM_RD || req.op == OP_MEM_WR) &&
      req.addr >= `IOD_EXT_LOW && req.addr <= `IOD_EXT_TOP
      |=> rsp.passOn && !rsp.refused && rsp.rdata == 8'h00)
      else $error("extended data access not passed on");

   data_alias_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      req.valid && req.op == OP_MEM_RD && req.addr >= `IOD_DATA_OFS &&
      req.addr <= `IOD_DATA_TOP
      |=> rsp.rdata == $past(ioMem[req.addr[5:0] - 6'h20] & rdMask(req.addr[5:0] - 6'h20)))
      else $error("data-space alias read wrong register");

   bit_only_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      req.valid && (req.op == OP_BIT_SET || req.op == OP_BIT_CLR) &&
      req.addr <= `IOD_BIT_TOP && !evt.valid
      |=> (ioMem[$past(req.addr[5:0])] & ~(8'h01 << $past(req.bitSel))) ==
          ($past(ioMem[req.addr[5:0]]) & ~(8'h01 << $past(req.bitSel))))
      else $error("bit operation disturbed other bits");

   flag_zero_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      req.valid && req.op == OP_PORT_WR && req.addr <= `IOD_PORT_TOP && !evt.valid
      |=> ((ioMem[$past(req.addr[5:0])] ^ $past(ioMem[req.addr[5:0]])) &
           clrMask($past(req.addr[5:0])) & ~$past(req.wdata)) == 8'h00)
      else $error("flag changed by a written zero");

   flag_one_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      req.valid && req.op == OP_PORT_WR && req.addr <= `IOD_PORT_TOP && !evt.valid
      |=> (ioMem[$past(req.addr[5:0])] & clrMask($past(req.addr[5:0])) &
           $past(req.wdata)) == 8'h00)
      else $error("flag not cleared by a written one");

   resv_read_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      req.valid && req.op == OP_PORT_RD && req.addr <= `IOD_PORT_TOP &&
      rdMask(req.addr[5:0]) == 8'h00 ##1 rsp.valid |-> rsp.rdata == 8'h00)
      else $error("reserved address read nonzero");

   // Refused port writes and data accesses passed onward leave the registers alone.
   port_keep_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      req.valid && req.op == OP_PORT_WR && req.addr > `IOD_PORT_TOP && !evt.valid
      |=> ioMem[$past(req.addr[5:0])] == $past(ioMem[req.addr[5:0]]))
      else $error("refused port write changed a register");

   pass_keep_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      req.valid && req.op == OP_MEM_WR && !evt.valid &&
      (req.addr < `IOD_DATA_OFS || req.addr > `IOD_DATA_TOP)
      |=> ioMem[$past(req.addr[5:0])] == $past(ioMem[req.addr[5:0]]))
      else $error("passed-on data write changed a register");

   // A data-space write lands in the I/O register 0x20 below its address.
   alias_write_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      req.valid && req.op == OP_MEM_WR && req.addr >= `IOD_DATA_OFS &&
      req.addr <= `IOD_DATA_TOP
      |=> (ioMem[$past(req.addr[5:0]) - 6'h20] & wrMask($past(req.addr[5:0]) - 6'h20)) ==
          $past(req.wdata & wrMask(req.addr[5:0] - 6'h20)))
      else $error("data-space alias write missed its register");

   // A skip answer follows the readable value of the addressed bit.
   skip_set_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      req.valid && req.op == OP_SKIP_SET && req.addr <= `IOD_BIT_TOP
      |=> rsp.skip == $past((ioMem[req.addr[5:0]] & rdMask(req.addr[5:0]) &
                             (8'h01 << req.bitSel)) != 8'h00))
      else $error("skip-if-set answer wrong");

   skip_clr_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      req.valid && req.op == OP_SKIP_CLR && req.addr <= `IOD_BIT_TOP
      |=> rsp.skip == $past((ioMem[req.addr[5:0]] & rdMask(req.addr[5:0]) &
                             (8'h01 << req.bitSel)) == 8'h00))
      else $error("skip-if-clear answer wrong");

   // Bits neither writable nor clear-by-one keep their value across a port write.
   resv_bits_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      req.valid && req.op == OP_PORT_WR && req.addr <= `IOD_PORT_TOP && !evt.valid
      |=> ((ioMem[$past(req.addr[5:0])] ^ $past(ioMem[req.addr[5:0]])) &
           ~$past(wrMask(req.addr[5:0]) | clrMask(req.addr[5:0]))) == 8'h00)
      else $error("write changed a reserved bit");

   // A peripheral raise sets its hardware bits, even against a clearing write.
   flag_set_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      evt.valid
      |=> (ioMem[$past(evt.ioAddr)] & $past(evt.bits & hwMask(evt.ioAddr))) ==
          $past(evt.bits & hwMask(evt.ioAddr)))
      else $error("raised flag not set");

endmodule : iod_decoder

// ===== sim/iod_core_model.sv
/*
 Behavioural model of the core that issues port, data-space and bit accesses.
 Assumes every task is entered just after a falling edge of sys_clk.
*/
`timescale 1ns/1ps

module iod_core_model
   import iod_pkg::*;
(
   input  wire logic     sys_clk,
   input  wire iod_rsp_s rsp,
   output iod_req_s      req
);
   // The core issues nothing and writes nothing until it is told to.
   initial begin
      req = '0;
   end

   // Holds one request over its taking edge and takes the answer in the cycle after it.
   task automatic access(input iod_op_e op, input logic [15:0] addr, input logic [2:0] bitSel,
                         input logic [7:0] wdata, output iod_rsp_s got);
      req <= '{valid: 1'b1, op: op, addr: addr, bitSel: bitSel, wdata: wdata};
      @(posedge sys_clk);
      @(negedge sys_clk);
      got = rsp;
   endtask : access

   // Drops the request; stale address and data are inverted so nothing leans on them.
   task automatic idle();
      req <= '{valid: 1'b0, op: req.op, addr: ~req.addr, bitSel: ~req.bitSel, wdata: ~req.wdata};
      @(negedge sys_clk);
   endtask : idle
endmodule : iod_core_model

// ===== sim/tb.sv
/*
 Self-checking bench of the I/O decoder: reset values, aliasing, access ranges,
 bit operations, flags and reserved places.
 Assumes the package, the decoder and the core model are compiled first.
*/
`timescale 1ns/1ps

module tb
   import iod_pkg::*;
;
   logic     sys_clk = 1'b0;
   logic     rst     = 1'b1;
   iod_req_s req;
   iod_evt_s evt     = '0;
   iod_rsp_s rsp;
   iod_rsp_s got;
   int       errors  = 0;
   int       n_tests = 0;

   // Clock of 100 ns period.
   always #50 sys_clk = ~sys_clk;

   // Core model drives requests; the bench plays the peripherals on the event port.
   iod_core_model i_core (.sys_clk(sys_clk), .rsp(rsp), .req(req));
   iod_decoder    i_dut  (.sys_clk(sys_clk), .rst(rst), .req(req), .evt(evt), .rsp(rsp));

   // Compares a read byte.
   task automatic check_data(input logic [7:0] act, input logic [7:0] exp);
      n_tests++;
      if (act !== exp) begin
         errors++;
         $display("[FAIL] %0t ns: data %h, expected %h", $time, act, exp);
      end
   endtask : check_data

   // Compares an answer flag.
   task automatic check_flag(input logic act, input logic exp);
      n_tests++;
      if (act !== exp) begin
         errors++;
         $display("[FAIL] %0t ns: flag %b, expected %b", $time, act, exp);
      end
   endtask : check_flag

   // One access through the core model; the answer lands in got.
   task automatic acc(input iod_op_e op, input logic [15:0] addr,
                      input logic [2:0] bitSel = 3'h0, input logic [7:0] wdata = 8'h00);
      i_core.access(op, addr, bitSel, wdata, got);
   endtask : acc

   // A one-cycle flag event from a peripheral.
   task automatic raise(input logic [5:0] ioAddr, input logic [7:0] bits);
      evt <= '{valid: 1'b1, ioAddr: ioAddr, bits: bits};
      @(negedge sys_clk);
      evt.valid <= 1'b0;
   endtask : raise

   // Every I/O place reads zero after reset through back-to-back port reads.
   task automatic t_reset();
      for (int a = 0; a < 64; a++) begin
         acc(OP_PORT_RD, 16'(a));
         check_flag(got.valid, 1'b1);
         check_flag(got.refused, 1'b0);
         check_data(got.rdata, 8'h00);
      end
      $display("t_reset done");
   endtask : t_reset

   // Port and data-space accesses reach the same register, back to back.
   task automatic t_alias();
      acc(OP_PORT_WR, 16'h003F, 3'h0, 8'hA5);
      acc(OP_MEM_RD, 16'h005F);
      check_data(got.rdata, 8'hA5);
      acc(OP_MEM_WR, 16'h0040, 3'h0, 8'h5A);
      acc(OP_PORT_RD, 16'h0020);
      check_data(got.rdata, 8'h5A);
      $display("t_alias done");
   endtask : t_alias

   // Port ops stop at 0x3F; the extended window passes on to loads and stores.
   task automatic t_range();
      acc(OP_PORT_RD, 16'h0040);
      check_flag(got.refused, 1'b1);
      acc(OP_PORT_WR, 16'h0060, 3'h0, 8'hFF);
      check_flag(got.refused, 1'b1);
      acc(OP_MEM_RD, 16'h0060);
      check_flag(got.passOn, 1'b1);
      check_data(got.rdata, 8'h00);
      acc(OP_MEM_WR, 16'h00FF, 3'h0, 8'h11);
      check_flag(got.passOn, 1'b1);
      $display("t_range done");
   endtask : t_range

   // Bit set, clear and skips on a plain low register, refused above 0x1F.
   task automatic t_bits();
      acc(OP_PORT_WR, 16'h0005, 3'h0, 8'h81);
      acc(OP_BIT_SET, 16'h0005, 3'h3);
      acc(OP_BIT_CLR, 16'h0005, 3'h7);
      acc(OP_PORT_RD, 16'h0005);
      check_data(got.rdata, 8'h09);
      acc(OP_SKIP_SET, 16'h0005, 3'h3);
      check_flag(got.skip, 1'b1);
      acc(OP_SKIP_CLR, 16'h0005, 3'h3);
      check_flag(got.skip, 1'b0);
      acc(OP_SKIP_CLR, 16'h001F, 3'h7);
      check_flag(got.refused, 1'b0);
      check_flag(got.skip, 1'b1);
      acc(OP_BIT_SET, 16'h0020, 3'h0);
      check_flag(got.refused, 1'b1);
      acc(OP_PORT_RD, 16'h0020);
      check_data(got.rdata, 8'h5A);
      $display("t_bits done");
   endtask : t_bits

   // Flags set by events clear only on a written one, bit ops touch one bit; a raise beats a clear.
   task automatic t_flags();
      i_core.idle();
      raise(6'h15, 8'h07);
      acc(OP_BIT_SET, 16'h0015, 3'h1);
      acc(OP_PORT_RD, 16'h0015);
      check_data(got.rdata, 8'h05);
      acc(OP_BIT_CLR, 16'h0015, 3'h0);
      acc(OP_PORT_WR, 16'h0015, 3'h0, 8'h00);
      acc(OP_PORT_WR, 16'h0015, 3'h0, 8'h04);
      acc(OP_PORT_RD, 16'h0015);
      check_data(got.rdata, 8'h01);
      i_core.idle();
      raise(6'h30, 8'h10);
      acc(OP_PORT_RD, 16'h0030);
      check_data(got.rdata, 8'h10);
      acc(OP_PORT_WR, 16'h0030, 3'h0, 8'h10);
      acc(OP_PORT_RD, 16'h0030);
      check_data(got.rdata, 8'h00);
      evt <= '{valid: 1'b1, ioAddr: 6'h30, bits: 8'h10};
      acc(OP_PORT_WR, 16'h0030, 3'h0, 8'h10);
      evt.valid <= 1'b0;
      acc(OP_PORT_RD, 16'h0030);
      check_data(got.rdata, 8'h10);
      $display("t_flags done");
   endtask : t_flags

   // Reserved places and reserved or write-only bits read zero; reserved places and bits keep nothing.
   task automatic t_reserved();
      acc(OP_PORT_WR, 16'h003C, 3'h0, 8'hFF);
      acc(OP_PORT_RD, 16'h003C);
      check_data(got.rdata, 8'h00);
      acc(OP_PORT_WR, 16'h003E, 3'h0, 8'hFF);
      acc(OP_PORT_RD, 16'h003E);
      check_data(got.rdata, 8'h07);
      acc(OP_MEM_WR, 16'h0045, 3'h0, 8'hFF);
      acc(OP_PORT_RD, 16'h0025);
      check_data(got.rdata, 8'h0F);
      acc(OP_BIT_SET, 16'h000C, 3'h0);
      acc(OP_PORT_RD, 16'h000C);
      check_data(got.rdata, 8'h00);
      $display("t_reserved done");
   endtask : t_reserved

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict

   // Holds reset for 16 cycles, releases it on a falling edge, runs every scenario.
   initial begin
      repeat (16) @(negedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_alias();
      t_range();
      t_bits();
      t_flags();
      t_reserved();
      i_core.idle();
      print_verdict();
   end
endmodule : tb
